// ==== sslp_axil_slave.sv ====
`timescale 1ns/1ns
`include "sslp_consts.svh"
// axi4-lite slave: one write and one read in flight, one-cycle answer
module sslp_axil_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [31:0] cur_val,     // current value at write address
    sslp_reg_if.slave        rif
);
    logic        aw_held_q;   // write address captured
    logic        w_held_q;    // write data captured
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  s_q;
    logic        aw_take;
    logic        w_take;
    logic        do_wr;
    logic [31:0] merged;
    logic        aw_held_d;   // next write address held
    logic        w_held_d;    // next write data held
    logic        bvalid_d;    // next response valid

    // address and data accepted in any order; stall while a response waits
    assign aw_take = awvalid && awready;
    assign w_take  = wvalid && wready;
    assign do_wr   = aw_held_q && w_held_q && !bvalid;
    // next holding state, so the readies can leave flops of their own
    assign aw_held_d = !do_wr && (aw_held_q || aw_take);
    assign w_held_d  = !do_wr && (w_held_q || w_take);
    assign bvalid_d  = do_wr || (bvalid && !bready);

    // byte lanes merge onto the live register value
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_lane
        assign merged[gi*8 +: 8] = s_q[gi] ? w_q[gi*8 +: 8] : cur_val[gi*8 +: 8];
    end
    assign rif.wr_en   = do_wr && rif.wr_hit;
    assign rif.wr_addr = {aw_q[7:2], 2'b00};
    assign rif.wr_data = merged;
    assign rif.rd_addr = {araddr[7:2], 2'b00};

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `SSLP_RESP_OKAY;
            aw_q      <= 8'h00;
            w_q       <= 32'h0000_0000;
            s_q       <= 4'h0;
            awready   <= 1'b1;
            wready    <= 1'b1;
        end else begin
            // readies registered from the next state, same value as before
            awready <= !aw_held_d && !bvalid_d;
            wready  <= !w_held_d && !bvalid_d;
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_q      <= awaddr;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_q      <= wdata;
                s_q      <= wstrb;
            end
            if (do_wr) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid    <= 1'b1;
                // read-only or unmapped targets answer slverr
                bresp     <= rif.wr_hit ? `SSLP_RESP_OKAY : `SSLP_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel: data registered the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `SSLP_RESP_OKAY;
            arready <= 1'b1;
        end else if (arvalid && arready) begin
            // no new address until this answer is taken
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata  <= rif.rd_data;
            rresp  <= rif.rd_hit ? `SSLP_RESP_OKAY : `SSLP_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

// ==== sslp_block_model.sv ====
`timescale 1ns/1ns
// stand-in for the host blocks and the processor core on the far side
module sslp_block_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [20:0] busy,           // blocks with work still pending
    input  wire logic        irq_req,        // one cycle: processor takes an irq
    input  wire logic        sleep_req,      // processor runs its sleep instruction
    input  wire logic        wake_req,       // a wake source fires
    output logic      [20:0] block_clk_need, // per-block clock request
    output logic             cpu_irq_vector, // one-cycle vector pulse
    output logic             cpu_sleep_req,  // processor parked in sleep
    output logic             wake_event      // wake source level
);
    // everything leaves through flops, as real blocks launch off the clock edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_clk_need <= 21'h000000;
            cpu_irq_vector <= 1'b0;
            cpu_sleep_req  <= 1'b0;
            wake_event     <= 1'b0;
        end else begin
            block_clk_need <= busy;
            cpu_irq_vector <= irq_req;
            // a woken processor drops its sleep request at once
            cpu_sleep_req  <= sleep_req & ~wake_req;
            wake_event     <= wake_req;
        end
    end
endmodule

// ==== sslp_consts.svh ====
`ifndef SSLP_CONSTS_SVH
`define SSLP_CONSTS_SVH
// register byte offsets
`define SSLP_OFF_HOST_SLEEP_EN     8'h10
`define SSLP_OFF_CLK_NEED          8'h14
`define SSLP_OFF_SLEEP_CTRL        8'h18
`define SSLP_OFF_SLEEP_STATUS      8'h1c
// control field positions
`define SSLP_BIT_OSC_PDN           0
`define SSLP_BIT_OSC_GATE          1
`define SSLP_BIT_REG_STBY          2
`define SSLP_BIT_SLEEP_ALL         4
`define SSLP_BIT_SLEEP_DEBUG       5
`define SSLP_BIT_AUTO_CLEAR        6
// writable masks, reserved bits stay zero
`define SSLP_CTRL_MASK             32'h0000_0077
`define SSLP_BLOCK_MASK            32'h001f_fc0f
`define SSLP_CTRL_RESET            32'h0000_0000
// axi responses
`define SSLP_RESP_OKAY             2'b00
`define SSLP_RESP_SLVERR           2'b10
// wake latencies in ns, clock period in ns
`define SSLP_CLK_PERIOD_NS         4
`define SSLP_WAKE_SLOW_NS          600000
`define SSLP_WAKE_FAST_NS          10000
`define SSLP_WAKE_SLOW_CYC         (`SSLP_WAKE_SLOW_NS / `SSLP_CLK_PERIOD_NS)
`define SSLP_WAKE_FAST_CYC         (`SSLP_WAKE_FAST_NS / `SSLP_CLK_PERIOD_NS)
`endif

// ==== sslp_pkg.sv ====
package sslp_pkg;
    // system sleep depth decoded from control bits 2:0
    typedef enum logic [1:0] {
        SSLP_HEAVY1,
        SSLP_HEAVY2,
        SSLP_HEAVY3,
        SSLP_DEEPEST
    } sslp_depth_type;
    // sequencer states
    typedef enum logic [1:0] {
        SSLP_RUN,
        SSLP_SLEEP,
        SSLP_LOCK
    } sslp_state_type;
endpackage

// ==== sslp_reg_if.sv ====
`timescale 1ns/1ns
// register handle between bus slave and sleep core
interface sslp_reg_if;
    logic        wr_en;   // one-cycle write strobe
    logic [7:0]  wr_addr; // word-aligned byte address
    logic [31:0] wr_data; // byte-merged write value
    logic [7:0]  rd_addr; // read address
    logic [31:0] rd_data; // read value
    logic        rd_hit;  // address is mapped
    logic        wr_hit;  // address is writable
    modport slave (output wr_en, wr_addr, wr_data, rd_addr, input rd_data, rd_hit, wr_hit);
    modport core  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data, rd_hit, wr_hit);
endinterface

// ==== sslp_sleep_ctrl.sv ====
`timescale 1ns/1ns
`include "sslp_consts.svh"
// Overview of operation
// - read-only clock-need vector, reserved bits zero
// - auto-clear drops sleep-all, debug on interrupt
// - debug-sleep bit readable and writable by firmware
// - sleep-all commands every block to sleep
// - regulator standby during sleep when bits 2 and 0 both set
// - gate oscillator output during sleep when bit 1 set and bit 0 clear
// - stop oscillator in sleep, wait lock on wake
// - sleep only when all commanded, none needs clock
// - depth decoded from control bits two to zero
// - no wake latency for gated or running oscillator
// - per-block enables command sleep, feed all-asleep
module sslp_sleep_ctrl #(
    parameter int NBLK           = 21,                    // host-facing block count
    parameter int LOCK_CYCLES    = `SSLP_WAKE_FAST_CYC,   // oscillator lock wait
    parameter int SLOW_WAKE_CYC  = `SSLP_WAKE_SLOW_CYC    // slow block wake wait
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // axi4-lite register port
    input  wire logic [7:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [7:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    // block side, same clock
    input  wire logic [NBLK-1:0] block_clk_need,     // block still needs clocks
    input  wire logic            cpu_irq_vector,     // pulse: processor vectors to irq
    input  wire logic            cpu_sleep_req,      // processor executed sleep
    input  wire logic            wake_event,         // level: wake source active
    output logic [NBLK-1:0]      block_sleep_cmd_q,  // per-block sleep command
    output logic                 sys_asleep_q,       // system in sleep state
    output logic                 reg_standby_q,      // core regulator standby
    output logic                 osc_gate_q,         // ring oscillator output gated
    output logic                 osc_power_down_q,   // ring oscillator stopped
    output logic                 clocks_ready_q      // clocks released to blocks
);
    sslp_reg_if rif ();

    logic [31:0]             ctrl_q;        // sleep control register
    logic [31:0]             ctrl_d;
    logic [NBLK-1:0]         slp_en_q;      // per-block sleep enables
    logic [NBLK-1:0]         need_q;        // sampled clock-need vector
    sslp_pkg::sslp_state_type state_q;
    sslp_pkg::sslp_state_type state_d;
    logic [17:0]             lock_cnt_q;    // oscillator relock counter
    logic [31:0]             cur_val;
    logic [31:0]             need_word;
    logic [31:0]             en_word;
    logic [31:0]             stat_word;
    logic                    all_cmd;
    logic                    none_need;
    logic                    can_sleep;
    logic                    hs_auto_clr;
    sslp_pkg::sslp_depth_type depth;
    logic                    osc_off;

    sslp_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .cur_val (cur_val),
        .rif     (rif)
    );

    // vectors widened to a word; reserved positions masked off
    assign need_word = 32'(need_q) & `SSLP_BLOCK_MASK;
    assign en_word   = 32'(slp_en_q) & `SSLP_BLOCK_MASK;
    assign stat_word = {28'h0000000, clocks_ready_q, osc_power_down_q,
                        state_q == sslp_pkg::SSLP_LOCK, sys_asleep_q};

    // read decode
    assign rif.rd_hit  = rif.rd_addr == `SSLP_OFF_HOST_SLEEP_EN || rif.rd_addr == `SSLP_OFF_CLK_NEED
                      || rif.rd_addr == `SSLP_OFF_SLEEP_CTRL || rif.rd_addr == `SSLP_OFF_SLEEP_STATUS;
    assign rif.rd_data = rif.rd_addr == `SSLP_OFF_HOST_SLEEP_EN ? en_word   :
                         rif.rd_addr == `SSLP_OFF_CLK_NEED      ? need_word :
                         rif.rd_addr == `SSLP_OFF_SLEEP_CTRL    ? ctrl_q    :
                         rif.rd_addr == `SSLP_OFF_SLEEP_STATUS  ? stat_word : 32'h0000_0000;
    // only the two control registers take writes; status words are read-only
    assign rif.wr_hit  = rif.wr_addr == `SSLP_OFF_HOST_SLEEP_EN
                      || rif.wr_addr == `SSLP_OFF_SLEEP_CTRL;
    assign cur_val     = rif.wr_addr == `SSLP_OFF_HOST_SLEEP_EN ? en_word : ctrl_q;

    // interrupt auto-clear of sleep-all and debug-sleep
    assign hs_auto_clr = cpu_irq_vector && ctrl_q[`SSLP_BIT_AUTO_CLEAR];

    // next control value; hardware clear is applied after the firmware write,
    // since the vector must leave the processor awake whatever firmware wrote
    always_comb begin
        ctrl_d = ctrl_q;
        if (rif.wr_en && rif.wr_addr == `SSLP_OFF_SLEEP_CTRL) begin
            ctrl_d = rif.wr_data & `SSLP_CTRL_MASK;
        end
        if (hs_auto_clr) begin
            ctrl_d[`SSLP_BIT_SLEEP_ALL]   = 1'b0;
            ctrl_d[`SSLP_BIT_SLEEP_DEBUG] = 1'b0;
        end
    end

    // all-blocks-commanded and none-need-clock qualifiers
    assign all_cmd   = ctrl_q[`SSLP_BIT_SLEEP_ALL]
                    || ((en_word | ~`SSLP_BLOCK_MASK) == 32'hffff_ffff);
    assign none_need = need_word == 32'h0000_0000;
    assign can_sleep = all_cmd && none_need && cpu_sleep_req && !wake_event;

    // sleep depth from control bits 2:0
    assign depth = ctrl_q[`SSLP_BIT_OSC_PDN]
                 ? (ctrl_q[`SSLP_BIT_REG_STBY] ? sslp_pkg::SSLP_DEEPEST : sslp_pkg::SSLP_HEAVY3)
                 : (ctrl_q[`SSLP_BIT_OSC_GATE] ? sslp_pkg::SSLP_HEAVY2 : sslp_pkg::SSLP_HEAVY1);
    assign osc_off = depth == sslp_pkg::SSLP_HEAVY3 || depth == sslp_pkg::SSLP_DEEPEST;

    // sequencer: run, sleep, relock after the oscillator was stopped
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sslp_pkg::SSLP_RUN: begin
                if (can_sleep) state_d = sslp_pkg::SSLP_SLEEP;
            end
            sslp_pkg::SSLP_SLEEP: begin
                // gated or running oscillator wakes at once
                if (wake_event) state_d = osc_power_down_q ? sslp_pkg::SSLP_LOCK
                                                           : sslp_pkg::SSLP_RUN;
            end
            sslp_pkg::SSLP_LOCK: begin
                if (lock_cnt_q == 18'd0) state_d = sslp_pkg::SSLP_RUN;
            end
        endcase
    end

    // register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= `SSLP_CTRL_RESET;
            slp_en_q <= '0;
            need_q   <= '0;
            state_q  <= sslp_pkg::SSLP_RUN;
        end else begin
            ctrl_q  <= ctrl_d;
            need_q  <= block_clk_need;
            state_q <= state_d;
            if (rif.wr_en && rif.wr_addr == `SSLP_OFF_HOST_SLEEP_EN) begin
                slp_en_q <= NBLK'(rif.wr_data & `SSLP_BLOCK_MASK);
            end
        end
    end

    // relock counter, loaded on every wake from sleep, whether the oscillator was off or not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_q <= 18'd0;
        end else if (state_q == sslp_pkg::SSLP_SLEEP && wake_event) begin
            lock_cnt_q <= 18'(LOCK_CYCLES - 1);
        end else if (lock_cnt_q != 18'd0) begin
            lock_cnt_q <= lock_cnt_q - 18'd1;
        end
    end

    // outputs; power controls latched while asleep so a register write cannot
    // change the depth under a sleeping chip
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_sleep_cmd_q <= '0;
            sys_asleep_q      <= 1'b0;
            reg_standby_q     <= 1'b0;
            osc_gate_q        <= 1'b0;
            osc_power_down_q  <= 1'b0;
            clocks_ready_q    <= 1'b1;
        end else begin
            block_sleep_cmd_q <= ctrl_q[`SSLP_BIT_SLEEP_ALL] ? '1 : slp_en_q;
            sys_asleep_q      <= state_d == sslp_pkg::SSLP_SLEEP;
            clocks_ready_q    <= state_d == sslp_pkg::SSLP_RUN;
            if (state_q == sslp_pkg::SSLP_RUN && state_d == sslp_pkg::SSLP_SLEEP) begin
                reg_standby_q    <= depth == sslp_pkg::SSLP_DEEPEST;
                osc_gate_q       <= depth == sslp_pkg::SSLP_HEAVY2;
                osc_power_down_q <= osc_off;
            end else if (state_d != sslp_pkg::SSLP_SLEEP) begin
                reg_standby_q    <= 1'b0;
                osc_gate_q       <= 1'b0;
                osc_power_down_q <= 1'b0;
            end
        end
    end

    // assertions
    property p_need_ro;
        @(posedge aclk) disable iff (!aresetn)
        need_word[31:21] == 11'h000 && need_word[9:4] == 6'h00;
    endproperty
    a_need_ro: assert property (p_need_ro) else $error("reserved clock-need bits set");

    property p_auto_clr;
        @(posedge aclk) disable iff (!aresetn)
        hs_auto_clr |=> !ctrl_q[`SSLP_BIT_SLEEP_ALL] && !ctrl_q[`SSLP_BIT_SLEEP_DEBUG];
    endproperty
    a_auto_clr: assert property (p_auto_clr) else $error("auto clear missed");

    property p_no_clr;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_irq_vector && !ctrl_q[`SSLP_BIT_AUTO_CLEAR] && !rif.wr_en)
            |=> $stable(ctrl_q);
    endproperty
    a_no_clr: assert property (p_no_clr) else $error("bits cleared without auto clear");

    property p_sleep_all;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_q[`SSLP_BIT_SLEEP_ALL] |=> &block_sleep_cmd_q;
    endproperty
    a_sleep_all: assert property (p_sleep_all) else $error("sleep all not broadcast");

    property p_standby;
        @(posedge aclk) disable iff (!aresetn)
        reg_standby_q |-> sys_asleep_q && osc_power_down_q;
    endproperty
    a_standby: assert property (p_standby) else $error("standby outside deepest");

    property p_gate;
        @(posedge aclk) disable iff (!aresetn)
        osc_gate_q |-> sys_asleep_q && !osc_power_down_q;
    endproperty
    a_gate: assert property (p_gate) else $error("gate outside sleep");

    sequence s_wake_off;
        sys_asleep_q && osc_power_down_q && wake_event;
    endsequence
    property p_relock;
        @(posedge aclk) disable iff (!aresetn)
        s_wake_off |=> !clocks_ready_q [*2];
    endproperty
    a_relock: assert property (p_relock) else $error("clocks before lock");

    property p_enter;
        @(posedge aclk) disable iff (!aresetn)
        $rose(sys_asleep_q) |-> $past(all_cmd) && $past(none_need);
    endproperty
    a_enter: assert property (p_enter) else $error("sleep without all commanded");

    property p_fast_wake;
        @(posedge aclk) disable iff (!aresetn)
        (sys_asleep_q && !osc_power_down_q && wake_event) |=> clocks_ready_q;
    endproperty
    a_fast_wake: assert property (p_fast_wake) else $error("latency on fast wake");
endmodule

// ==== system_sleep_controller_tb.sv ====
`timescale 1ns/1ns
`include "sslp_consts.svh"
// self-checking bench: register bus master plus block-side stimulus
module system_sleep_controller_tb;
    localparam int LOCK = 4;          // shortened relock wait keeps the run short
    logic        aclk     = 1'b0;     // 250 MHz clock
    logic        aresetn  = 1'b0;     // synchronous reset, active low
    logic [7:0]  awaddr   = 8'h00;
    logic [7:0]  araddr   = 8'h00;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic [31:0] wdata    = 32'h00000000;
    logic [3:0]  wstrb    = 4'h0;
    logic [20:0] busy     = 21'h000000;
    logic        irq_req  = 1'b0;
    logic        slp_req  = 1'b0;
    logic        wake_req = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, sreq, wake;
    logic        asleep, stby, gate, pdn, rdy;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [20:0] need, cmd;
    int          n_errors = 0;        // mismatches seen
    int          n_tests  = 0;        // comparisons made

    always #2 aclk = ~aclk;

    sslp_sleep_ctrl #(.LOCK_CYCLES(LOCK)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .block_clk_need(need), .cpu_irq_vector(irq),
        .cpu_sleep_req(sreq), .wake_event(wake), .block_sleep_cmd_q(cmd),
        .sys_asleep_q(asleep), .reg_standby_q(stby), .osc_gate_q(gate),
        .osc_power_down_q(pdn), .clocks_ready_q(rdy));

    sslp_block_model peer (.aclk(aclk), .aresetn(aresetn), .busy(busy), .irq_req(irq_req),
        .sleep_req(slp_req), .wake_req(wake_req), .block_clk_need(need),
        .cpu_irq_vector(irq), .cpu_sleep_req(sreq), .wake_event(wake));

    task automatic finish_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // handshakes are judged at the falling edge, where nothing is moving
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic at, wt, ta, tw;
        at = 1'b0;
        wt = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(at && wt)) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            at = at | ta;
            wt = wt | tw;
        end
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        bus_write(a, d, r);
        chk("write response", 32'(`SSLP_RESP_OKAY), 32'(r));
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        bus_read(a, d, r);
        chk(name, e, d);
    endtask

    // counts falling edges until the flag rises, bounded; sel 0 asleep, 1 clocks ready
    task automatic wait_flag(input bit sel, output int n);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while ((sel ? rdy : asleep) !== 1'b1 && n < 40);
        @(posedge aclk);
    endtask

    task automatic t_reset();
        chk("cmd after reset", 32'h0, 32'(cmd));
        chk("ready after reset", 32'h1, 32'(rdy));
        rd_chk("ctrl reset", `SSLP_OFF_SLEEP_CTRL, 32'h0);
        rd_chk("enables reset", `SSLP_OFF_HOST_SLEEP_EN, 32'h0);
        rd_chk("status reset", `SSLP_OFF_SLEEP_STATUS, 32'h8);
    endtask

    // reserved bits drop writes, read-only and unmapped places answer with an error
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`SSLP_OFF_SLEEP_CTRL, 32'hffffffff);
        rd_chk("ctrl mask", `SSLP_OFF_SLEEP_CTRL, 32'h77);
        wr(`SSLP_OFF_HOST_SLEEP_EN, 32'hffffffff);
        rd_chk("enable mask", `SSLP_OFF_HOST_SLEEP_EN, 32'h001ffc0f);
        bus_write(`SSLP_OFF_CLK_NEED, 32'hffffffff, r);
        chk("ro write resp", 32'(`SSLP_RESP_SLVERR), 32'(r));
        bus_read(8'h40, d, r);
        chk("unmapped resp", 32'(`SSLP_RESP_SLVERR), 32'(r));
        chk("unmapped data", 32'h0, d);
        wr(`SSLP_OFF_SLEEP_CTRL, 32'h0);
        wr(`SSLP_OFF_HOST_SLEEP_EN, 32'h0);
    endtask

    task automatic t_need();
        busy <= 21'h1fffff;
        repeat (4) @(posedge aclk);
        rd_chk("need vector", `SSLP_OFF_CLK_NEED, 32'h001ffc0f);
        busy <= 21'h000000;
        repeat (4) @(posedge aclk);
        rd_chk("need clear", `SSLP_OFF_CLK_NEED, 32'h0);
    endtask

    task automatic t_cmd();
        wr(`SSLP_OFF_SLEEP_CTRL, 32'h10);
        repeat (2) @(posedge aclk);
        chk("sleep all cmd", 32'h1fffff, 32'(cmd));
        wr(`SSLP_OFF_SLEEP_CTRL, 32'h0);
        wr(`SSLP_OFF_HOST_SLEEP_EN, 32'h001ffc0d);
        repeat (2) @(posedge aclk);
        chk("enable cmd", 32'h001ffc0d, 32'(cmd));
    endtask

    // sleep is held off by a busy block or by one block left enabled to run
    task automatic t_gate();
        int n;
        slp_req <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("one block awake", 32'h0, 32'(asleep));
        busy <= 21'h000001;
        wr(`SSLP_OFF_HOST_SLEEP_EN, 32'h001ffc0f);
        repeat (10) @(posedge aclk);
        chk("busy block", 32'h0, 32'(asleep));
        busy <= 21'h000000;
        wait_flag(1'b0, n);
        chk("all idle sleeps", 32'h1, 32'(asleep));
        rd_chk("status asleep", `SSLP_OFF_SLEEP_STATUS, 32'h1);
        wake_req <= 1'b1;
        slp_req <= 1'b0;
        wait_flag(1'b1, n);
        wake_req <= 1'b0;
        wr(`SSLP_OFF_HOST_SLEEP_EN, 32'h0);
    endtask

    task automatic t_depth();
        logic [2:0] codes [6] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b101, 3'b111};
        int n;
        foreach (codes[i]) begin
            // sleep-all at bit 4, bit 3 stays reserved
            wr(`SSLP_OFF_SLEEP_CTRL, {27'h0, 2'b10, codes[i]});
            slp_req <= 1'b1;
            wait_flag(1'b0, n);
            chk("asleep", 32'h1, 32'(asleep));
            chk("standby", 32'(codes[i][2]), 32'(stby));
            chk("osc off", 32'(codes[i][0]), 32'(pdn));
            if (!codes[i][0]) chk("osc gate", 32'(codes[i][1]), 32'(gate));
            chk("clocks held", 32'h0, 32'(rdy));
            wake_req <= 1'b1;
            slp_req <= 1'b0;
            wait_flag(1'b1, n);
            if (codes[i][0]) chk("relock wait", 32'h1, 32'(n >= LOCK + 2 && n <= LOCK + 4));
            else chk("no wake latency", 32'h1, 32'(n <= 3));
            chk("awake outputs", 32'h0, 32'({stby, gate, pdn, asleep}));
            wake_req <= 1'b0;
        end
        wr(`SSLP_OFF_SLEEP_CTRL, 32'h0);
    endtask

    task automatic t_autoclear();
        wr(`SSLP_OFF_SLEEP_CTRL, 32'h30);
        irq_req <= 1'b1;
        @(posedge aclk);
        irq_req <= 1'b0;
        repeat (3) @(posedge aclk);
        rd_chk("no auto clear", `SSLP_OFF_SLEEP_CTRL, 32'h30);
        wr(`SSLP_OFF_SLEEP_CTRL, 32'h71);
        irq_req <= 1'b1;
        @(posedge aclk);
        irq_req <= 1'b0;
        repeat (3) @(posedge aclk);
        rd_chk("auto clear", `SSLP_OFF_SLEEP_CTRL, 32'h41);
    endtask

    // watchdog: the whole run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_regs();
        t_need();
        t_cmd();
        t_gate();
        t_depth();
        t_autoclear();
        finish_test();
    end
endmodule
